// *** bench/atx_line_rx.sv ***
`timescale 1ns/10ps
module atx_line_rx #(
  parameter int BIT_T = 16
) (
  input  wire logic       clock,
  input  wire logic       pin,
  input  wire logic       nine,
  output logic [8:0]      word,
  output int              frames
);
  // listens only; a frame whose stop slot is low (break) is not counted
  initial begin
    word = '0;
    frames = 0;
    forever begin
      @(negedge pin);
      repeat (BIT_T / 2) @(posedge clock);
      if (pin === 1'b0) begin
        // no bit of an earlier, longer word may linger
        word = '0;
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
          repeat (BIT_T) @(posedge clock);
          word[i] = pin;
        end
        repeat (BIT_T) @(posedge clock);
        if (pin === 1'b1) begin
          frames++;
        end
      end
    end
  end
endmodule : atx_line_rx

// *** bench/atx_transmitter_chk.sv ***
`timescale 1ns/10ps
module atx_transmitter_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic txEnable,
  input wire logic rxEnable,
  input wire logic txEmptyIrqEnable,
  input wire logic cpuIrqMask,
  input wire logic wrValid,
  input wire logic wrReady,
  input wire logic txPinOut,
  input wire logic txPinOe,
  input wire logic txBufferEmptyFlag,
  input wire logic txCompleteFlag,
  input wire logic txIrq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  sequence emptyIrqCond;
    txBufferEmptyFlag && txEmptyIrqEnable && !cpuIrqMask;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  oe_release_a: assert property (!txEnable && !rxEnable |=> !txPinOe)
    else $error("pin kept after both paths off");
  oe_take_a: assert property (txEnable || rxEnable |=> txPinOe)
    else $error("pin not taken while enabled");
  empty_clr_a: assert property ($fell(txBufferEmptyFlag) |->
    $past(wrValid && wrReady) || $past(wrValid && wrReady, 2))
    else $error("empty flag fell without a write");
  done_clr_a: assert property ($fell(txCompleteFlag) |->
    $past(wrValid && wrReady) || $past(wrValid && wrReady, 2))
    else $error("complete flag fell without a write");
  empty_irq_a: assert property (emptyIrqCond ##1 emptyIrqCond |-> txIrq)
    else $error("no irq for empty flag");
  irq_mask_a: assert property (cpuIrqMask ##1 cpuIrqMask |-> !txIrq)
    else $error("irq while masked");
  start_low_a: assert property ($fell(txPinOut) |-> !txPinOut [*8])
    else $error("start slot cut short");
  stop_high_a: assert property ($rose(txCompleteFlag) |->
    $past(txPinOut) && $past(txPinOut, 8))
    else $error("frame ended without high stop slot");
endmodule : atx_transmitter_chk

bind atx_transmitter atx_transmitter_chk u_chk (
  .clock(clock), .rst(rst), .txEnable(txEnable), .rxEnable(rxEnable),
  .txEmptyIrqEnable(txEmptyIrqEnable), .cpuIrqMask(cpuIrqMask),
  .wrValid(wrValid), .wrReady(wrReady), .txPinOut(txPinOut),
  .txPinOe(txPinOe), .txBufferEmptyFlag(txBufferEmptyFlag),
  .txCompleteFlag(txCompleteFlag), .txIrq(txIrq)
);

// *** bench/atx_transmitter_tb.sv ***
`timescale 1ns/10ps
module atx_transmitter_tb;
  import atx_pkg::*;
  localparam int BIT_T = 16; // divisor 1 with baudCfg all zero
  logic           clock;
  logic           rst;
  logic           txEnable;
  logic           rxEnable;
  atx_frame_cfg_t frameCfg;
  atx_baud_cfg_t  baudCfg;
  logic           sendBreak;
  logic           txEmptyIrqEnable;
  logic           txCompleteIrqEnable;
  logic           cpuIrqMask;
  logic           statusRead;
  logic           wrValid;
  logic [7:0]     wrData;
  logic           wrReady;
  logic           txPinOut;
  logic           txPinOe;
  logic           txBufferEmptyFlag;
  logic           txCompleteFlag;
  logic           txIrq;
  logic           line;
  logic [8:0]     rxWord;
  int             rxFrames;
  int             num_errors;
  int             comparisons;
  // pull-up while the port releases the pin
  assign line = txPinOe ? txPinOut : 1'b1;
  atx_transmitter u_dut (
    .clock(clock), .rst(rst), .txEnable(txEnable), .rxEnable(rxEnable),
    .frameCfg(frameCfg), .baudCfg(baudCfg), .sendBreak(sendBreak),
    .txEmptyIrqEnable(txEmptyIrqEnable),
    .txCompleteIrqEnable(txCompleteIrqEnable), .cpuIrqMask(cpuIrqMask),
    .statusRead(statusRead), .wrValid(wrValid), .wrData(wrData),
    .wrReady(wrReady), .txPinOut(txPinOut), .txPinOe(txPinOe),
    .txBufferEmptyFlag(txBufferEmptyFlag),
    .txCompleteFlag(txCompleteFlag), .txIrq(txIrq)
  );
  atx_line_rx #(.BIT_T(BIT_T)) u_rx (
    .clock(clock), .pin(line), .nine(frameCfg.wordLen9),
    .word(rxWord), .frames(rxFrames)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic send(input logic [7:0] w);
    @(negedge clock);
    wrValid = 1'b1;
    wrData = w;
    do @(posedge clock); while (wrReady !== 1'b1);
    @(negedge clock);
    wrValid = 1'b0;
  endtask : send
  task automatic sread();
    @(negedge clock);
    statusRead = 1'b1;
    @(negedge clock);
    statusRead = 1'b0;
  endtask : sread
  // returns after the stop slot has run out
  task automatic waitf(input int n);
    int f0;
    f0 = rxFrames;
    wait (rxFrames >= f0 + n);
    repeat (BIT_T) @(negedge clock);
  endtask : waitf
  task automatic count_low(input int n, output int lows);
    lows = 0;
    repeat (n) begin
      @(negedge clock);
      lows += int'(line === 1'b0);
    end
  endtask : count_low
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_idle();
    int lows;
    txEnable = 1'b1;
    send(8'ha5);
    count_low(140, lows);
    check(9'(lows), 9'h0);
    waitf(1);
    check(rxWord, 9'h0a5);
  endtask : t_idle
  task automatic t_pair();
    sread();
    send(8'h3c);
    repeat (3) @(negedge clock);
    check(9'(txBufferEmptyFlag), 9'h1);
    sread();
    send(8'hc3);
    repeat (3) @(negedge clock);
    check(9'({txBufferEmptyFlag, txCompleteFlag}), 9'h0);
    waitf(2);
    check(rxWord, 9'h0c3);
    check(9'({txBufferEmptyFlag, txCompleteFlag}), 9'h3);
  endtask : t_pair
  task automatic t_irq();
    {txEmptyIrqEnable, cpuIrqMask} = 2'h2;
    repeat (3) @(negedge clock);
    check(9'(txIrq), 9'h1);
    cpuIrqMask = 1'b1;
    repeat (3) @(negedge clock);
    check(9'(txIrq), 9'h0);
    {txEmptyIrqEnable, txCompleteIrqEnable, cpuIrqMask} = 3'h2;
    repeat (3) @(negedge clock);
    check(9'(txIrq), 9'h1);
    txCompleteIrqEnable = 1'b0;
  endtask : t_irq
  task automatic t_fmt(input atx_frame_cfg_t c, input logic [7:0] d,
                       input logic [8:0] e);
    frameCfg = c;
    send(d);
    waitf(1);
    check(rxWord, e);
  endtask : t_fmt
  task automatic t_brk();
    int lows;
    sendBreak = 1'b1;
    // the first break frame and most of the second must stay low with no gap between them
    count_low(300, lows);
    check(9'(lows), 9'h12c);
    sendBreak = 1'b0;
    send(8'h55);
    waitf(1);
    check(rxWord, 9'h055);
  endtask : t_brk
  task automatic t_full();
    int f0;
    wrData = 8'h11;
    wrValid = 1'b1;
    statusRead = 1'b1;
    repeat (8) @(negedge clock);
    check(9'({wrReady, txBufferEmptyFlag}), 9'h0);
    wrValid = 1'b0;
    statusRead = 1'b0;
    f0 = rxFrames;
    txEnable = 1'b0;
    @(negedge clock);
    txEnable = 1'b1;
    repeat (3) @(negedge clock);
    check(9'(txBufferEmptyFlag), 9'h1);
    repeat (700) @(negedge clock);
    check(9'(rxFrames - f0), 9'h1);
  endtask : t_full
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    stop_test();
  end
  initial begin
    {rst, txEnable, rxEnable, sendBreak, statusRead, wrValid} = 6'h20;
    {txEmptyIrqEnable, txCompleteIrqEnable, cpuIrqMask} = 3'h1;
    frameCfg = '0;
    baudCfg = '0; // held still for the whole run
    wrData = '0;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    check(9'({txPinOut, txPinOe, txBufferEmptyFlag, txCompleteFlag, txIrq}),
          9'h16);
    t_idle();
    t_pair();
    t_irq();
    t_fmt(4'h9, 8'h5a, 9'h15a);
    t_fmt(4'h8, 8'hff, 9'h0ff);
    t_fmt(4'h4, 8'h07, 9'h087);
    t_fmt(4'h6, 8'h07, 9'h007);
    t_fmt(4'hc, 8'h07, 9'h107);
    frameCfg = '0;
    t_brk();
    t_full();
    stop_test();
  end
endmodule : atx_transmitter_tb

// *** rtl/atx_baud_gen.sv ***
`timescale 1ns/10ps
`include "atx_defs.svh"
module atx_baud_gen #(
  parameter int CNT_W = 19
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire atx_pkg::atx_baud_cfg_t baudCfg,
  output logic                       baudTick
);
  import atx_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             tick_d;
  logic [CNT_W-1:0] divisor;

  function automatic logic [CNT_W-1:0] divisorOf(atx_baud_cfg_t c);
    logic [CNT_W-1:0] pr;
    logic [CNT_W-1:0] base;
    unique case (c.coarsePrescaleFactor)
      2'h0: pr = CNT_W'(`ATX_PR_A);
      2'h1: pr = CNT_W'(`ATX_PR_B);
      2'h2: pr = CNT_W'(`ATX_PR_C);
      2'h3: pr = CNT_W'(`ATX_PR_D);
    endcase
    base = pr << c.txRateDivider;
    if (c.txExtendedPrescaler != 8'h00) begin
      divisorOf = CNT_W'(base * CNT_W'(c.txExtendedPrescaler));
    end else begin
      divisorOf = base;
    end
  endfunction : divisorOf

  // settings are not resynchronised mid-count, software keeps them still
  always_comb begin
    divisor = divisorOf(baudCfg);
    tick_d  = (cnt_q >= divisor - CNT_W'(1));
    cnt_d   = tick_d ? '0 : cnt_q + CNT_W'(1);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_q    <= '0;
      baudTick <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      baudTick <= tick_d;
    end
  end
endmodule : atx_baud_gen

// *** rtl/atx_defs.svh ***
`ifndef ATX_DEFS_SVH
`define ATX_DEFS_SVH
`define ATX_TICK_LAST   4'hf
`define ATX_SLOTS_8     4'ha
`define ATX_SLOTS_9     4'hb
`define ATX_SLOTS_EXTRA 4'h1
`define ATX_PR_A        19'h00001
`define ATX_PR_B        19'h00003
`define ATX_PR_C        19'h00004
`define ATX_PR_D        19'h0000d
`define ATX_EMPTY_RST   1'b1
`define ATX_DONE_RST    1'b1
`define ATX_LINE_IDLE   1'b1
`define ATX_START_BIT   1'b0
`define ATX_STOP_BIT    1'b1
`endif

// *** rtl/atx_pkg.sv ***
package atx_pkg;
  typedef struct packed {
    logic       wordLen9;
    logic       parityEnable;
    logic       parityOdd;
    logic       txNinthBit;
  } atx_frame_cfg_t;

  typedef struct packed {
    logic [1:0] coarsePrescaleFactor;
    logic [2:0] txRateDivider;
    logic [7:0] txExtendedPrescaler;
  } atx_baud_cfg_t;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_READY,
    ST_SEND
  } atx_state_t;
endpackage : atx_pkg

// *** rtl/atx_skid_buf.sv ***
`timescale 1ns/10ps
module atx_skid_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    rdPtr_q;
  logic [AW-1:0]    wrPtr_q;
  logic [AW:0]      count_q;
  logic [AW-1:0]    rdPtr_d;
  logic [AW-1:0]    wrPtr_d;
  logic [AW:0]      count_d;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] bump(logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : bump

  always_comb begin
    push    = inValid & inReady;
    pop     = outValid & outReady;
    rdPtr_d = pop ? bump(rdPtr_q) : rdPtr_q;
    wrPtr_d = push ? bump(wrPtr_q) : wrPtr_q;
    count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      rdPtr_d = '0;
      wrPtr_d = '0;
      count_d = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdPtr_q  <= '0;
      wrPtr_q  <= '0;
      count_q  <= '0;
      inReady  <= 1'b1;
      outValid <= 1'b0;
    end else begin
      rdPtr_q  <= rdPtr_d;
      wrPtr_q  <= wrPtr_d;
      count_q  <= count_d;
      inReady  <= (count_d != (AW+1)'(DEPTH));
      outValid <= (count_d != '0);
    end
  end

  // storage carries no reset, only the pointers, count and handshake flags do
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  assign outData = mem_q[rdPtr_q];
endmodule : atx_skid_buf

// *** rtl/atx_transmitter.sv ***
`timescale 1ns/10ps
`include "atx_defs.svh"
module atx_transmitter #(
  parameter int DATA_W  = 8,
  parameter int BUF_DEP = 2,
  parameter int BAUD_W  = 19
) (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic                    txEnable,
  input  wire logic                    rxEnable,
  input  wire atx_pkg::atx_frame_cfg_t frameCfg,
  input  wire atx_pkg::atx_baud_cfg_t  baudCfg,
  input  wire logic                    sendBreak,
  input  wire logic                    txEmptyIrqEnable,
  input  wire logic                    txCompleteIrqEnable,
  input  wire logic                    cpuIrqMask,
  input  wire logic                    statusRead,
  input  wire logic                    wrValid,
  input  wire logic [DATA_W-1:0]       wrData,
  output logic                         wrReady,
  output logic                         txPinOut,
  output logic                         txPinOe,
  output logic                         txBufferEmptyFlag,
  output logic                         txCompleteFlag,
  output logic                         txIrq
);
  import atx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  atx_state_t       state_q;
  atx_state_t       state_d;
  logic [10:0]      shift_q;
  logic [10:0]      shift_d;
  logic [3:0]       slots_q;
  logic [3:0]       slots_d;
  logic [3:0]       tickCnt_q;
  logic [3:0]       tickCnt_d;
  logic             pin_d;
  logic             oe_d;
  logic             teLast_q;
  logic             idlePend_q;
  logic             idlePend_d;
  logic             breakSent_q;
  logic             breakSent_d;
  logic             empty_d;
  logic             done_d;
  logic             armed_q;
  logic             armed_d;
  logic             irq_d;
  logic             teRise;
  logic             teFall;
  logic             wrTaken;
  logic             frameEnd;
  logic             baudTick;
  logic             bufValid;
  logic             bufPop;
  logic [DATA_W-1:0] bufData;

  ////////////////////////////////////////////////////////////////////////////
  // frame builders

  function automatic logic [3:0] slotsFor(logic wl9);
    slotsFor = wl9 ? `ATX_SLOTS_9 : `ATX_SLOTS_8;
  endfunction : slotsFor

  // slot 0 is the start bit, shifted out first
  function automatic logic [10:0] dataFrame(logic [DATA_W-1:0] d,
                                            atx_frame_cfg_t c);
    logic [8:0] word;
    logic       par;
    word = {c.txNinthBit, d};
    if (c.parityEnable) begin
      if (c.wordLen9) begin
        par     = (^d) ^ c.parityOdd;
        word[8] = par;
      end else begin
        par     = (^d[6:0]) ^ c.parityOdd;
        word[7] = par;
      end
    end
    if (c.wordLen9) begin
      dataFrame = {`ATX_STOP_BIT, word, `ATX_START_BIT};
    end else begin
      dataFrame = {`ATX_LINE_IDLE, `ATX_STOP_BIT, word[7:0],
                   `ATX_START_BIT};
    end
  endfunction : dataFrame

  ////////////////////////////////////////////////////////////////////////////
  // baud generator and write buffer

  atx_baud_gen #(
    .CNT_W    (BAUD_W)
  ) u_baud (
    .clock    (clock),
    .rst      (rst),
    .baudCfg  (baudCfg),
    .baudTick (baudTick)
  );

  // a falling txEnable throws away every word not yet in the shifter
  atx_skid_buf #(
    .WIDTH    (DATA_W),
    .DEPTH    (BUF_DEP)
  ) u_buf (
    .clock    (clock),
    .rst      (rst),
    .flush    (teFall),
    .inValid  (wrValid),
    .inReady  (wrReady),
    .inData   (wrData),
    .outValid (bufValid),
    .outReady (bufPop),
    .outData  (bufData)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transmit sequencer

  always_comb begin
    state_d     = state_q;
    shift_d     = shift_q;
    slots_d     = slots_q;
    tickCnt_d   = tickCnt_q;
    idlePend_d  = idlePend_q;
    breakSent_d = breakSent_q;
    bufPop      = 1'b0;
    frameEnd    = 1'b0;
    teRise      = txEnable & ~teLast_q;
    teFall      = ~txEnable & teLast_q;
    unique case (state_q)
      ST_OFF: begin
        if (txEnable) begin
          shift_d    = '1;
          slots_d    = slotsFor(frameCfg.wordLen9);
          tickCnt_d  = '0;
          idlePend_d = 1'b0;
          state_d    = ST_SEND;
        end
      end
      ST_READY: begin
        tickCnt_d = '0;
        if (!txEnable) begin
          state_d = ST_OFF;
        end else if (sendBreak) begin
          shift_d     = '0;
          slots_d     = slotsFor(frameCfg.wordLen9);
          breakSent_d = 1'b1;
          state_d     = ST_SEND;
        end else if (breakSent_q) begin
          shift_d     = '1;
          slots_d     = `ATX_SLOTS_EXTRA;
          breakSent_d = 1'b0;
          state_d     = ST_SEND;
        end else if (bufValid) begin
          bufPop  = 1'b1;
          shift_d = dataFrame(bufData, frameCfg);
          slots_d = slotsFor(frameCfg.wordLen9);
          state_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (teRise) begin
          idlePend_d = 1'b1;
        end
        if (baudTick) begin
          if (tickCnt_q == `ATX_TICK_LAST) begin
            tickCnt_d = '0;
            if (slots_q == `ATX_SLOTS_EXTRA) begin
              frameEnd = 1'b1;
            end else begin
              shift_d = {`ATX_LINE_IDLE, shift_q[10:1]};
              slots_d = slots_q - 4'h1;
            end
          end else begin
            tickCnt_d = tickCnt_q + 4'h1;
          end
        end
        if (frameEnd) begin
          if (!txEnable) begin
            state_d = ST_OFF;
          end else if (idlePend_d) begin
            shift_d    = '1;
            slots_d    = slotsFor(frameCfg.wordLen9);
            idlePend_d = 1'b0;
          end else if (sendBreak) begin
            // chained, so the line does not pulse high between break frames unless a txEnable rise has set idlePend and queued an idle frame
            shift_d     = '0;
            slots_d     = slotsFor(frameCfg.wordLen9);
            breakSent_d = 1'b1;
          end else begin
            shift_d = '1;
            state_d = ST_READY;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive

  always_comb begin
    oe_d  = txEnable | rxEnable;
    pin_d = `ATX_LINE_IDLE;
    // only the shifter's own slot reaches the line, else it rests high
    if (state_d == ST_SEND) begin
      pin_d = shift_d[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags and interrupt

  always_comb begin
    wrTaken = wrValid & wrReady;
    armed_d = armed_q;
    empty_d = txBufferEmptyFlag;
    done_d  = txCompleteFlag;
    if (wrTaken && armed_q) begin
      empty_d = 1'b0;
      done_d  = 1'b0;
      armed_d = 1'b0;
    end
    if (statusRead) begin
      armed_d = 1'b1;
    end
    // hardware sets are written last so they win over a clear
    if (bufPop || teFall) begin
      empty_d = 1'b1;
    end
    if (frameEnd) begin
      done_d = 1'b1;
    end
    irq_d = ~cpuIrqMask &
            ((empty_d & txEmptyIrqEnable) |
             (done_d & txCompleteIrqEnable));
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // sequencer state
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q     <= ST_OFF;
      shift_q     <= '1;
      slots_q     <= '0;
      tickCnt_q   <= '0;
      teLast_q    <= 1'b0;
      idlePend_q  <= 1'b0;
      breakSent_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      shift_q     <= shift_d;
      slots_q     <= slots_d;
      tickCnt_q   <= tickCnt_d;
      teLast_q    <= txEnable;
      idlePend_q  <= idlePend_d;
      breakSent_q <= breakSent_d;
    end
  end

  // pin drive, registered so the line never glitches
  always_ff @(posedge clock) begin
    if (rst) begin
      txPinOut <= `ATX_LINE_IDLE;
      txPinOe  <= 1'b0;
    end else begin
      txPinOut <= pin_d;
      txPinOe  <= oe_d;
    end
  end

  // flags, clear arming and interrupt
  always_ff @(posedge clock) begin
    if (rst) begin
      armed_q           <= 1'b0;
      txBufferEmptyFlag <= `ATX_EMPTY_RST;
      txCompleteFlag    <= `ATX_DONE_RST;
      txIrq             <= 1'b0;
    end else begin
      armed_q           <= armed_d;
      txBufferEmptyFlag <= empty_d;
      txCompleteFlag    <= done_d;
      txIrq             <= irq_d;
    end
  end
endmodule : atx_transmitter
